// >>> rtl/eps_status_objects.sv
`timescale 1ns/1ns
`default_nettype none
module eps_status_objects (
    input  wire logic               clk,
    input  wire logic               srst,
    input  wire logic signed [31:0] position,
    input  wire logic               pos_valid,
    input  wire logic        [15:0] oper_param,
    input  wire logic               position_fault,
    input  wire logic               position_accurate,
    input  wire logic        [3:0]  vendor_alarm_in,
    input  wire logic        [3:0]  vendor_warn_in,
    input  wire logic               store_req,
    input  wire logic        [15:0] od_index,
    input  wire logic               od_rd,
    input  wire logic               od_wr,
    input  wire logic        [31:0] od_wdata,
    output logic             [31:0] od_rdata,
    output logic                    od_ack,
    output logic                    od_err,
    output logic             [7:0]  area_state,
    output logic                    position_invalid,
    output logic                    boot_done
);

    // ****************************************
    // Decode helpers
    // ****************************************
    // Both aliases of each limit resolve to the same storage
    function automatic logic eps_is_low(input logic [15:0] idx);
        eps_is_low = (idx == eps_pkg::IDX_LOW_LIMIT) || (idx == eps_pkg::IDX_MFR_MIN);
    endfunction

    function automatic logic eps_is_high(input logic [15:0] idx);
        eps_is_high = (idx == eps_pkg::IDX_HIGH_LIMIT) || (idx == eps_pkg::IDX_MFR_MAX);
    endfunction

    // ****************************************
    // State and storage
    // ****************************************
    eps_pkg::eps_state_type state;
    eps_pkg::eps_state_type next_state;

    logic signed [31:0] low_limit;
    logic signed [31:0] high_limit;
    logic        [15:0] opstat;
    logic        [15:0] alarm_word;
    logic        [15:0] warn_word;
    logic        [31:0] nv_rdata;
    logic               underflow;
    logic               overflow;

    // ****************************************
    // Sequencer
    // ****************************************
    // Boot walks the two retained words, store writes them back
    always_comb begin
        next_state = state;
        case (state)
            eps_pkg::ST_BOOT_LOW: begin
                next_state = eps_pkg::ST_BOOT_HIGH;
            end
            eps_pkg::ST_BOOT_HIGH: begin
                next_state = eps_pkg::ST_BOOT_LAST;
            end
            eps_pkg::ST_BOOT_LAST: begin
                next_state = eps_pkg::ST_RUN;
            end
            eps_pkg::ST_RUN: begin
                if (store_req) begin
                    next_state = eps_pkg::ST_STORE_LOW;
                end
            end
            eps_pkg::ST_STORE_LOW: begin
                next_state = eps_pkg::ST_STORE_HIGH;
            end
            eps_pkg::ST_STORE_HIGH: begin
                next_state = eps_pkg::ST_RUN;
            end
            default: begin
                next_state = eps_pkg::ST_BOOT_LOW;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state <= eps_pkg::ST_BOOT_LOW;
        end else begin
            state <= next_state;
        end
    end

    wire logic booting    = (state == eps_pkg::ST_BOOT_LOW) || (state == eps_pkg::ST_BOOT_HIGH)
                          || (state == eps_pkg::ST_BOOT_LAST);
    wire logic nv_wr      = (state == eps_pkg::ST_STORE_LOW) || (state == eps_pkg::ST_STORE_HIGH);
    wire logic nv_wr_addr = (state == eps_pkg::ST_STORE_HIGH) ? eps_pkg::NV_ADDR_HIGH : eps_pkg::NV_ADDR_LOW;
    wire logic [31:0] nv_wr_data = (state == eps_pkg::ST_STORE_HIGH) ? high_limit : low_limit;
    wire logic nv_rd_addr = (state == eps_pkg::ST_BOOT_LOW) ? eps_pkg::NV_ADDR_LOW : eps_pkg::NV_ADDR_HIGH;

    eps_nv_store u_nv (
        .clk     (clk),
        .wr_en   (nv_wr),
        .wr_addr (nv_wr_addr),
        .wr_data (nv_wr_data),
        .rd_addr (nv_rd_addr),
        .rd_data (nv_rdata)
    );

    // ****************************************
    // Access decode
    // ****************************************
    wire logic idx_low    = eps_is_low(od_index);
    wire logic idx_high   = eps_is_high(od_index);
    wire logic idx_warn   = (od_index == eps_pkg::IDX_WARN);
    wire logic idx_ro     = (od_index == eps_pkg::IDX_OPSTAT) || (od_index == eps_pkg::IDX_STEPS)
                          || (od_index == eps_pkg::IDX_REVS) || (od_index == eps_pkg::IDX_ALARM)
                          || (od_index == eps_pkg::IDX_ALARM_SUP) || (od_index == eps_pkg::IDX_WARN_SUP)
                          || (od_index == eps_pkg::IDX_VERSION);
    wire logic writable   = idx_low || idx_high || idx_warn;
    wire logic mapped     = writable || idx_ro;
    wire logic access     = od_rd || od_wr;
    // Writes to read-only targets and accesses to unknown indices are refused; a write to the warning index is acknowledged and dropped
    wire logic bad_access = access && (booting || !mapped || (od_wr && !writable));
    wire logic wr_low     = od_wr && !booting && idx_low;
    wire logic wr_high    = od_wr && !booting && idx_high;

    // ****************************************
    // Work-area limits
    // ****************************************
    // Boot restore takes priority; bus writes only land in service
    always_ff @(posedge clk) begin
        if (srst) begin
            low_limit  <= eps_pkg::LIMIT_RESET;
            high_limit <= eps_pkg::LIMIT_RESET;
        end else begin
            if (state == eps_pkg::ST_BOOT_HIGH) begin
                low_limit <= nv_rdata;
            end else if (wr_low) begin
                low_limit <= od_wdata;
            end
            if (state == eps_pkg::ST_BOOT_LAST) begin
                high_limit <= nv_rdata;
            end else if (wr_high) begin
                high_limit <= od_wdata;
            end
        end
    end

    eps_limit_cmp u_cmp (
        .clk        (clk),
        .srst       (srst),
        .sample     (pos_valid),
        .position   (position),
        .low_limit  (low_limit),
        .high_limit (high_limit),
        .underflow  (underflow),
        .overflow   (overflow)
    );

    // ****************************************
    // Status words
    // ****************************************
    // Sticky alarm: a fault in the clearing cycle keeps the bit set
    wire logic [15:0] alarm_raw  = {vendor_alarm_in, 11'h000, position_fault};
    wire logic [15:0] next_alarm = alarm_raw | (position_accurate ? 16'h0000 : alarm_word);
    // Warnings are live levels, so they drop as soon as tolerances recover
    wire logic [15:0] next_warn  = {vendor_warn_in, 12'h000} & eps_pkg::WARN_SUPPORT;

    always_ff @(posedge clk) begin
        if (srst) begin
            alarm_word       <= 16'h0000;
            warn_word        <= 16'h0000;
            position_invalid <= 1'b0;
            opstat           <= 16'h0000;
            area_state       <= 8'h00;
        end else begin
            alarm_word       <= next_alarm;
            warn_word        <= next_warn;
            position_invalid <= |next_alarm;
            opstat           <= oper_param;
            area_state       <= {5'h00, underflow, overflow, 1'b0};
        end
    end

    // ****************************************
    // Read mux and answer
    // ****************************************
    wire logic [31:0] version = {eps_pkg::SW_VER_UPPER, eps_pkg::SW_VER_LOWER,
                                 eps_pkg::PROF_VER_UPPER, eps_pkg::PROF_VER_LOWER};
    wire logic [31:0] rd_value =
        idx_low                                ? low_limit :
        idx_high                               ? high_limit :
        (od_index == eps_pkg::IDX_OPSTAT)      ? {16'h0000, opstat} :
        (od_index == eps_pkg::IDX_STEPS)       ? eps_pkg::STEPS_PER_REV :
        (od_index == eps_pkg::IDX_REVS)        ? {16'h0000, eps_pkg::REV_RANGE} :
        (od_index == eps_pkg::IDX_ALARM)       ? {16'h0000, alarm_word} :
        (od_index == eps_pkg::IDX_ALARM_SUP)   ? {16'h0000, eps_pkg::ALARM_SUPPORT} :
        idx_warn                               ? {16'h0000, warn_word} :
        (od_index == eps_pkg::IDX_WARN_SUP)    ? {16'h0000, eps_pkg::WARN_SUPPORT} :
        (od_index == eps_pkg::IDX_VERSION)     ? version : 32'h0000_0000;

    // One answer per request, the cycle after it
    always_ff @(posedge clk) begin
        if (srst) begin
            od_rdata  <= 32'h0000_0000;
            od_ack    <= 1'b0;
            od_err    <= 1'b0;
            boot_done <= 1'b0;
        end else begin
            od_rdata  <= (od_rd && !bad_access) ? rd_value : 32'h0000_0000;
            od_ack    <= access && !bad_access;
            od_err    <= bad_access;
            boot_done <= !booting;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking dc @(posedge clk); endclocking
    default disable iff (srst);

    a_underflow_flag: assert property (pos_valid && (position <= low_limit) |=> ##1 area_state[2])
        else $error("underflow flag missing");
    a_overflow_flag: assert property (pos_valid && (position >= high_limit) |=> ##1 area_state[1])
        else $error("overflow flag missing");
    a_inside_area: assert property (pos_valid && (position > low_limit) && (position < high_limit)
                                    |=> ##1 (area_state[2:1] == 2'b00))
        else $error("flag set inside work area");
    a_low_alias: assert property (od_wr && !booting && (od_index == eps_pkg::IDX_MFR_MIN)
                                  |=> (low_limit == $past(od_wdata)))
        else $error("minimum alias write lost");
    a_high_alias: assert property (od_rd && !booting && (od_index == eps_pkg::IDX_MFR_MAX) && !wr_high
                                   |=> (od_rdata == high_limit) && od_ack)
        else $error("maximum alias read differs");
    a_limit_reset: assert property (disable iff (1'b0) srst |=> (low_limit == 32'h0) && (high_limit == 32'h0))
        else $error("limit not cleared by reset");
    a_opstat_mirror: assert property (od_rd && !booting && (od_index == eps_pkg::IDX_OPSTAT)
                                      |=> (od_rdata[15:0] == $past(oper_param, 2)))
        else $error("operating status not mirrored");
    a_steps_const: assert property (od_rd && !booting && (od_index == eps_pkg::IDX_STEPS)
                                    |=> od_ack && (od_rdata == eps_pkg::STEPS_PER_REV))
        else $error("steps per revolution wrong");
    a_alarm_raise: assert property (position_fault |=> alarm_word[0] && position_invalid)
        else $error("alarm not raised");
    a_alarm_hold: assert property (alarm_word[0] && !position_accurate |=> alarm_word[0])
        else $error("alarm dropped early");
    a_warn_autoclear: assert property ((vendor_warn_in == 4'h0) |=> (warn_word == 16'h0000))
        else $error("warning not cleared");
    a_warn_no_invalid: assert property (!position_fault && (vendor_alarm_in == 4'h0) && position_accurate
                                        |=> !position_invalid)
        else $error("warning made position invalid");
    a_revs_const: assert property (od_rd && !booting && (od_index == eps_pkg::IDX_REVS)
                                   |=> od_ack && (od_rdata == {16'h0000, eps_pkg::REV_RANGE}))
        else $error("revolution count wrong");
    a_alarm_layout: assert property (alarm_word[11:1] == 11'h000)
        else $error("reserved alarm bit set");
    a_warn_masked: assert property ((warn_word & ~eps_pkg::WARN_SUPPORT) == 16'h0000)
        else $error("unsupported warning bit set");
    a_ro_refused: assert property (od_wr && (od_index == eps_pkg::IDX_VERSION) |=> od_err && !od_ack)
        else $error("write to version accepted");

endmodule
`default_nettype wire

// >>> rtl/eps_pkg.sv
package eps_pkg;

    // ****************************************
    // Object dictionary indices
    // ****************************************
    localparam logic [15:0] IDX_LOW_LIMIT  = 16'h6401;
    localparam logic [15:0] IDX_HIGH_LIMIT = 16'h6402;
    localparam logic [15:0] IDX_MFR_MIN    = 16'h2104;
    localparam logic [15:0] IDX_MFR_MAX    = 16'h2105;
    localparam logic [15:0] IDX_OPSTAT     = 16'h6500;
    localparam logic [15:0] IDX_STEPS      = 16'h6501;
    localparam logic [15:0] IDX_REVS       = 16'h6502;
    localparam logic [15:0] IDX_ALARM      = 16'h6503;
    localparam logic [15:0] IDX_ALARM_SUP  = 16'h6504;
    localparam logic [15:0] IDX_WARN       = 16'h6505;
    localparam logic [15:0] IDX_WARN_SUP   = 16'h6506;
    localparam logic [15:0] IDX_VERSION    = 16'h6507;

    // ****************************************
    // Reset values and constants
    // ****************************************
    localparam logic [31:0] LIMIT_RESET    = 32'h0000_0000;
    localparam logic [15:0] ALARM_SUPPORT  = 16'h1000;
    localparam logic [15:0] WARN_SUPPORT   = 16'h1000;
    localparam logic [31:0] STEPS_PER_REV  = 32'h0000_2000;
    localparam logic [15:0] REV_RANGE      = 16'h1000;
    // Version bytes: values are arbitrary
    localparam logic [7:0]  SW_VER_UPPER   = 8'h01;
    localparam logic [7:0]  SW_VER_LOWER   = 8'h00;
    localparam logic [7:0]  PROF_VER_UPPER = 8'h01;
    localparam logic [7:0]  PROF_VER_LOWER = 8'h00;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int AREA_UNDER_BIT  = 2;
    localparam int AREA_OVER_BIT   = 1;
    localparam int ALARM_POS_BIT   = 0;
    localparam int VENDOR_LSB      = 12;
    localparam int WARN_FIELD_MSB  = 5;

    // Non-volatile word addresses
    localparam logic NV_ADDR_LOW  = 1'b0;
    localparam logic NV_ADDR_HIGH = 1'b1;
    localparam int   NV_DEPTH     = 2;

    typedef enum logic [2:0] {
        ST_BOOT_LOW,
        ST_BOOT_HIGH,
        ST_BOOT_LAST,
        ST_RUN,
        ST_STORE_LOW,
        ST_STORE_HIGH
    } eps_state_type;

endpackage

// >>> rtl/eps_nv_store.sv
`timescale 1ns/1ns
`default_nettype none
module eps_nv_store (
    input  wire logic        clk,
    input  wire logic        wr_en,
    input  wire logic        wr_addr,
    input  wire logic [31:0] wr_data,
    input  wire logic        rd_addr,
    output logic      [31:0] rd_data
);

    // ****************************************
    // Retained limit storage
    // ****************************************
    // No reset: contents must survive a soft reset of the logic
    logic [31:0] mem [0:eps_pkg::NV_DEPTH-1];

    // Blank part reads zero until first stored
    initial begin
        for (int i = 0; i < eps_pkg::NV_DEPTH; i++) begin
            mem[i] = 32'h0000_0000;
        end
    end

    // Write port
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Registered read, one cycle latency
    always_ff @(posedge clk) begin
        rd_data <= mem[rd_addr];
    end

endmodule
`default_nettype wire

// >>> rtl/eps_limit_cmp.sv
`timescale 1ns/1ns
`default_nettype none
module eps_limit_cmp (
    input  wire logic               clk,
    input  wire logic               srst,
    input  wire logic               sample,
    input  wire logic signed [31:0] position,
    input  wire logic signed [31:0] low_limit,
    input  wire logic signed [31:0] high_limit,
    output logic                    underflow,
    output logic                    overflow
);

    // ****************************************
    // Work-area comparison
    // ****************************************
    // Signed compare so negative positions behave
    wire logic at_low  = (position <= low_limit);
    wire logic at_high = (position >= high_limit);

    // Flags follow each new sample and hold between samples
    always_ff @(posedge clk) begin
        if (srst) begin
            underflow <= 1'b0;
            overflow  <= 1'b0;
        end else if (sample) begin
            underflow <= at_low;
            overflow  <= at_high;
        end
    end

endmodule
`default_nettype wire

// >>> testbench/eps_od_master.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Dictionary master standing on the bus side
// ****************************************
module eps_od_master (
    output logic      [15:0] od_index,
    output logic             od_rd,
    output logic             od_wr,
    output logic      [31:0] od_wdata,
    input  wire logic        clk,
    input  wire logic [31:0] od_rdata,
    input  wire logic        od_ack,
    input  wire logic        od_err
);
    // Idle bus at time zero
    initial begin
        od_index = 16'h0000;
        od_rd    = 1'b0;
        od_wr    = 1'b0;
        od_wdata = 32'h0000_0000;
    end

    // One access: pulse for one cycle, answer lands on the taking edge and is read 1 ns later
    // Released index and data are inverted so a stale value can never look valid
    task automatic access(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                          output logic [31:0] rd, output logic ack, output logic err);
        @(posedge clk);
        od_index <= idx;
        od_wdata <= wd;
        od_rd    <= ~wr;
        od_wr    <= wr;
        @(posedge clk);
        od_rd    <= 1'b0;
        od_wr    <= 1'b0;
        od_index <= ~idx;
        od_wdata <= ~wd;
        #1;
        rd  = od_rdata;
        ack = od_ack;
        err = od_err;
    endtask
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic               clk = 1'b0;
    logic               srst = 1'b1;
    logic signed [31:0] position = 32'sh0;
    logic               pos_valid = 1'b0;
    logic        [15:0] oper_param = 16'h5a3c;
    logic               position_fault = 1'b0;
    logic               position_accurate = 1'b0;
    logic        [3:0]  vendor_alarm_in = 4'h0;
    logic        [3:0]  vendor_warn_in = 4'h0;
    logic               store_req = 1'b0;
    logic        [15:0] od_index;
    logic               od_rd;
    logic               od_wr;
    logic        [31:0] od_wdata;
    logic        [31:0] od_rdata;
    logic               od_ack;
    logic               od_err;
    logic        [7:0]  area_state;
    logic               position_invalid;
    logic               boot_done;
    int                 failures = 0;
    int                 n_compared = 0;
    int                 cycles = 0;

    typedef struct {logic wr; logic [15:0] idx; logic [31:0] wd; logic err; logic [31:0] rd;} eps_row_type;
    // Ordinary accesses: write flag, index, data, refusal, read value
    eps_row_type rows[17] = '{
        '{1'b0, 16'h6504, 32'h0, 1'b0, 32'h0000_1000},
        '{1'b0, 16'h6506, 32'h0, 1'b0, 32'h0000_1000},
        '{1'b0, 16'h6501, 32'h0, 1'b0, 32'h0000_2000},
        '{1'b0, 16'h6502, 32'h0, 1'b0, 32'h0000_1000},
        '{1'b0, 16'h6507, 32'h0, 1'b0, 32'h0100_0100},
        '{1'b0, 16'h6401, 32'h0, 1'b0, 32'h0},
        '{1'b0, 16'h6402, 32'h0, 1'b0, 32'h0},
        '{1'b0, 16'h6500, 32'h0, 1'b0, 32'h0000_5a3c},
        '{1'b1, 16'h2104, 32'hffff_fff0, 1'b0, 32'h0},
        '{1'b0, 16'h6401, 32'h0, 1'b0, 32'hffff_fff0},
        '{1'b0, 16'h2104, 32'h0, 1'b0, 32'hffff_fff0},
        '{1'b1, 16'h6402, 32'h0000_0064, 1'b0, 32'h0},
        '{1'b0, 16'h2105, 32'h0, 1'b0, 32'h0000_0064},
        '{1'b1, 16'h6501, 32'h1, 1'b1, 32'h0},
        '{1'b1, 16'h6504, 32'h1, 1'b1, 32'h0},
        '{1'b1, 16'h6507, 32'h1, 1'b1, 32'h0},
        '{1'b0, 16'h1234, 32'h0, 1'b1, 32'h0}
    };

    eps_status_objects i_eps_status_objects (
        .clk(clk), .srst(srst), .position(position), .pos_valid(pos_valid),
        .oper_param(oper_param), .position_fault(position_fault),
        .position_accurate(position_accurate), .vendor_alarm_in(vendor_alarm_in),
        .vendor_warn_in(vendor_warn_in), .store_req(store_req), .od_index(od_index),
        .od_rd(od_rd), .od_wr(od_wr), .od_wdata(od_wdata), .od_rdata(od_rdata),
        .od_ack(od_ack), .od_err(od_err), .area_state(area_state),
        .position_invalid(position_invalid), .boot_done(boot_done)
    );

    eps_od_master i_eps_od_master (
        .clk(clk), .od_index(od_index), .od_rd(od_rd), .od_wr(od_wr),
        .od_wdata(od_wdata), .od_rdata(od_rdata), .od_ack(od_ack), .od_err(od_err)
    );

    // ****************************************
    // Clock, watchdog and shared tasks
    // ****************************************
    initial begin
        forever #50 clk = ~clk;
    end

    // A hang is cut short well above the expected run length
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures = failures + 1;
            results();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Access and compare; read data only matters when the access is accepted
    task automatic acc(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                       input logic exp_err, input logic [31:0] exp_rd);
        logic [31:0] rd;
        logic        ack;
        logic        err;
        i_eps_od_master.access(wr, idx, wd, rd, ack, err);
        check({30'h0, ack, err}, {30'h0, ~exp_err, exp_err});
        if (!exp_err) begin
            check(rd, exp_rd);
        end
    endtask

    // One sample pulse, then the flags two edges after the taking edge
    task automatic sample(input logic signed [31:0] p, input logic [7:0] exp);
        @(posedge clk);
        position  <= p;
        pos_valid <= 1'b1;
        @(posedge clk);
        pos_valid <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check({24'h0, area_state}, {24'h0, exp});
    endtask

    task automatic reset_and_boot();
        @(posedge clk);
        srst <= 1'b1;
        repeat (5) @(posedge clk);
        #1;
        check({30'h0, boot_done, od_ack}, 32'h0);
        check({24'h0, area_state}, 32'h0);
        // Release on an edge; the first access lands while boot restore still runs
        @(posedge clk);
        srst <= 1'b0;
        acc(1'b0, 16'h6401, 32'h0, 1'b1, 32'h0);
        for (int i = 0; i < 20 && boot_done !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        check({31'h0, boot_done}, 32'h1);
    endtask

    task automatic results();
        if (failures == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        reset_and_boot();
        foreach (rows[i]) begin
            acc(rows[i].wr, rows[i].idx, rows[i].wd, rows[i].err, rows[i].rd);
        end
        // Limits are now -16 and 100; both boundaries and one step past
        sample(-32'sd16, 8'h04);
        sample(-32'sd17, 8'h04);
        sample(32'sd100, 8'h02);
        sample(32'sd50, 8'h00);
        sample(32'sd101, 8'h02);
        sample(-32'sd15, 8'h00);
        // Operating status follows a change without any write
        @(posedge clk);
        oper_param <= 16'h0ff0;
        acc(1'b0, 16'h6500, 32'h0, 1'b0, 32'h0000_0ff0);
        // Alarm is sticky across reads and across the fault going away
        @(posedge clk);
        position_fault  <= 1'b1;
        vendor_alarm_in <= 4'h1;
        @(posedge clk);
        position_fault  <= 1'b0;
        vendor_alarm_in <= 4'h0;
        acc(1'b0, 16'h6503, 32'h0, 1'b0, 32'h0000_1001);
        acc(1'b0, 16'h6503, 32'h0, 1'b0, 32'h0000_1001);
        check({31'h0, position_invalid}, 32'h1);
        @(posedge clk);
        position_accurate <= 1'b1;
        repeat (3) @(posedge clk);
        acc(1'b0, 16'h6503, 32'h0, 1'b0, 32'h0);
        check({31'h0, position_invalid}, 32'h0);
        // Warnings pass only the supported bit and never mark the position invalid
        @(posedge clk);
        vendor_warn_in <= 4'hf;
        acc(1'b0, 16'h6505, 32'h0, 1'b0, 32'h0000_1000);
        check({31'h0, position_invalid}, 32'h0);
        acc(1'b1, 16'h6505, 32'h0, 1'b0, 32'h0);
        acc(1'b0, 16'h6505, 32'h0, 1'b0, 32'h0000_1000);
        @(posedge clk);
        vendor_warn_in <= 4'h0;
        acc(1'b0, 16'h6505, 32'h0, 1'b0, 32'h0);
        // Saved limits come back after a second reset
        @(posedge clk);
        store_req <= 1'b1;
        @(posedge clk);
        store_req <= 1'b0;
        repeat (4) @(posedge clk);
        reset_and_boot();
        acc(1'b0, 16'h6401, 32'h0, 1'b0, 32'hffff_fff0);
        acc(1'b0, 16'h6402, 32'h0, 1'b0, 32'h0000_0064);
        results();
    end
endmodule
`default_nettype wire
